// ==== rtl/csb_defs.svh ====
// constants for the processor sideband control block
`ifndef CSB_DEFS_SVH
`define CSB_DEFS_SVH
`define CSB_SYNC_STAGES      2
`define CSB_VEC_W            32
`define CSB_RESET_VECTOR     32'hFFFF_FFF0
`define CSB_LOCK_SEQ_MAX     8'h04
`endif

// ==== rtl/csb_pkg.sv ====
// types for the processor sideband control block
package csb_pkg;
    // core-side event request bundle
    typedef struct packed {
        logic fp_op_valid;
        logic fp_op_control;
        logic fp_error_set;
        logic native_fp_error_bit;
    } csb_fp_req_t;

    // synchronised pin levels
    typedef struct packed {
        logic ignore_fp_error_n;
        logic init_n;
        logic local_irq_pin_zero;
        logic local_irq_pin_one;
    } csb_pins_t;

    typedef enum logic [2:0] {
        CSB_IDLE = 3'b001,
        CSB_LOCK = 3'b010,
        CSB_INIT = 3'b100
    } csb_state_t;
endpackage

// ==== rtl/csb_sync.sv ====
// two-flop synchroniser for a group of asynchronous pins
`timescale 1ns/1ns
`include "csb_defs.svh"
module csb_sync #(
    parameter int               WIDTH     = 4,
    parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
    // clock and reset
    input  wire logic             i_clk_sys,
    input  wire logic             i_rst_n,
    input  wire logic             i_ce,
    // pins
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] sync;
    } csb_sync_st_t;

    csb_sync_st_t st;
    csb_sync_st_t next_st;

    // the first stage feeds only the second stage
    always_comb begin
        next_st = st;
        if (i_ce) begin
            next_st.meta = i_async;
            next_st.sync = st.meta;
        end
    end

    // reset to the pins' idle level so that no false event follows reset
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st <= {RESET_VAL, RESET_VAL};
        end else begin
            st <= next_st;
        end
    end

    assign o_sync = st.sync;
endmodule

// ==== rtl/csb_top.sv ====
// processor sideband control: numeric-error gating, soft init, local irq fallback, bus lock
// Operation
// [RULE1] with ignore input asserted, pending fp error is ignored, no exception
// [RULE2] with ignore input deasserted, pending error raises exception on noncontrol fp op
// [RULE3] native error bit set makes the ignore input have no effect
// [RULE4] system holds ignore input valid by target ready of the io write
// [RULE5] soft init resets integer state, keeps caches and fp registers
// [RULE6] after soft init, fetch restarts at the configured reset vector
// [RULE7] snoop requests are serviced throughout soft init assertion
// [RULE8] controller disabled: pin zero is maskable irq, pin one is nmi
// [RULE9] local interrupt controller is enabled after reset
// [RULE10] bus lock asserted from first transaction start to last transaction end
// [RULE11] priority agent waits for lock deasserted before taking the bus
// [RULE12] bus ownership kept for the whole locked operation
// [RULE13] asynchronous inputs pass two flip-flops before use
`timescale 1ns/1ns
`include "csb_defs.svh"
module csb_top
    import csb_pkg::*;
#(
    parameter logic [`CSB_VEC_W-1:0] RESET_VECTOR = `CSB_RESET_VECTOR
) (
    // clock, reset, enable
    input  wire logic                  i_clk_sys,
    input  wire logic                  i_rst_n,
    input  wire logic                  i_ce,
    // asynchronous pins
    input  wire logic                  i_ignore_fp_error_n,
    input  wire logic                  i_init_n,
    input  wire logic [1:0]            i_local_irq_pins,
    // core-side floating-point events
    input  wire csb_fp_req_t           i_fp,
    // core-side configuration
    input  wire logic                  i_lapic_disable,
    input  wire logic                  i_lapic_enable,
    // core-side bus sequencing
    input  wire logic                  i_lock_seq_start,
    input  wire logic                  i_lock_seq_end,
    input  wire logic                  i_snoop_req,
    // exception and init outputs
    output logic                       o_fp_exception,
    output logic                       o_fp_error_pending,
    output logic                       o_int_reg_reset,
    output logic                       o_fetch_restart,
    output logic [`CSB_VEC_W-1:0]      o_fetch_vector,
    output logic                       o_snoop_ack,
    // interrupt outputs
    output logic                       o_lapic_enabled,
    output logic                       o_maskable_irq,
    output logic                       o_nmi,
    output logic [1:0]                 o_lapic_lint,
    // bus lock
    output logic                       o_bus_lock_n,
    output logic                       o_bus_lock_oe,
    output logic                       o_bus_own_hold
);
    typedef struct packed {
        csb_state_t            state;
        logic                  err_pending;
        logic                  fp_exc;
        logic                  int_reset;
        logic                  restart;
        logic [`CSB_VEC_W-1:0] vector;
        logic                  snoop_ack;
        logic                  lapic_en;
        logic                  maskable_irq;
        logic                  nmi;
        logic [1:0]            lint;
        logic                  lock_n;
        logic                  lock_oe;
        logic                  own_hold;
    } csb_st_t;

    csb_st_t   st;
    csb_st_t   next_st;
    csb_pins_t pins;
    logic      rst_int_n;
    logic      ignore_active;
    logic      init_active;
    logic [3:0] sync_in;
    logic [3:0] sync_out;

    // reset release: separate small process because the reset itself is its source
    logic [1:0] rst_ff;
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_ff <= 2'h0;
        end else begin
            rst_ff <= {rst_ff[0], 1'b1};
        end
    end
    assign rst_int_n = rst_ff[1];

    assign sync_in = {i_ignore_fp_error_n, i_init_n, ~i_local_irq_pins[0], ~i_local_irq_pins[1]};

    csb_sync #(
        .WIDTH     (4),
        .RESET_VAL (4'hF)
    ) u_sync (
        .i_clk_sys   (i_clk_sys),
        .i_rst_n     (rst_int_n),
        .i_ce        (i_ce),
        .i_async     (sync_in), // RULE13
        .o_sync      (sync_out)
    );

    always_comb begin
        pins.ignore_fp_error_n  = sync_out[3];
        pins.init_n             = sync_out[2];
        pins.local_irq_pin_zero = ~sync_out[1];
        pins.local_irq_pin_one  = ~sync_out[0];
    end

    // native mode bit overrides the pin completely
    assign ignore_active = !pins.ignore_fp_error_n && !i_fp.native_fp_error_bit; // RULE3
    assign init_active   = !pins.init_n;

    always_comb begin
        next_st           = st;
        next_st.fp_exc    = 1'b0;
        next_st.restart   = 1'b0;
        // snoops are answered in every state, soft init included
        next_st.snoop_ack = i_snoop_req; // RULE7
        if (i_fp.fp_error_set) begin
            next_st.err_pending = 1'b1;
        end
        if (i_fp.fp_op_valid && !i_fp.fp_op_control && st.err_pending) begin
            // ignored: error stays pending, execution continues
            if (!ignore_active) begin // RULE1
                next_st.fp_exc      = 1'b1; // RULE2
                next_st.err_pending = i_fp.fp_error_set;
            end
        end
        if (i_lapic_disable) begin
            next_st.lapic_en = 1'b0;
        end else if (i_lapic_enable) begin
            next_st.lapic_en = 1'b1;
        end
        if (st.lapic_en) begin
            next_st.lint         = {pins.local_irq_pin_one, pins.local_irq_pin_zero};
            next_st.maskable_irq = 1'b0;
            next_st.nmi          = 1'b0;
        end else begin
            next_st.lint         = 2'h0;
            next_st.maskable_irq = pins.local_irq_pin_zero; // RULE8
            next_st.nmi          = pins.local_irq_pin_one; // RULE8
        end
        unique case (st.state)
            CSB_IDLE: begin
                next_st.own_hold = 1'b0;
                if (init_active) begin
                    next_st.state     = CSB_INIT;
                    next_st.int_reset = 1'b1; // RULE5
                end else if (i_lock_seq_start) begin
                    next_st.state    = CSB_LOCK;
                    next_st.lock_n   = 1'b0; // RULE10
                    next_st.lock_oe  = 1'b1;
                    next_st.own_hold = 1'b1; // RULE12
                end
            end
            CSB_LOCK: begin
                // a soft init waits for the lock to finish so atomicity is never broken
                if (i_lock_seq_end) begin
                    next_st.state    = CSB_IDLE;
                    next_st.lock_n   = 1'b1; // RULE10
                    next_st.lock_oe  = 1'b0;
                    next_st.own_hold = 1'b0;
                end
            end
            CSB_INIT: begin
                if (!init_active) begin
                    next_st.state     = CSB_IDLE;
                    next_st.int_reset = 1'b0;
                    next_st.restart   = 1'b1; // RULE6
                    next_st.vector    = RESET_VECTOR; // RULE6
                end
            end
        endcase
        if (!i_ce) begin
            next_st = st;
        end
    end

    always_ff @(posedge i_clk_sys or negedge rst_int_n) begin
        if (!rst_int_n) begin
            st              <= '0;
            st.state        <= CSB_IDLE;
            st.lapic_en     <= 1'b1; // RULE9
            st.lock_n       <= 1'b1;
            st.vector       <= RESET_VECTOR;
        end else begin
            st <= next_st;
        end
    end

    assign o_fp_exception     = st.fp_exc;
    assign o_fp_error_pending = st.err_pending;
    assign o_int_reg_reset    = st.int_reset;
    assign o_fetch_restart    = st.restart;
    assign o_fetch_vector     = st.vector;
    assign o_snoop_ack        = st.snoop_ack;
    assign o_lapic_enabled    = st.lapic_en;
    assign o_maskable_irq     = st.maskable_irq;
    assign o_nmi              = st.nmi;
    assign o_lapic_lint       = st.lint;
    assign o_bus_lock_n       = st.lock_n;
    assign o_bus_lock_oe      = st.lock_oe;
    assign o_bus_own_hold     = st.own_hold;

    // assertions
    sequence lock_open_s;
        st.state == CSB_IDLE && !init_active && i_lock_seq_start && i_ce;
    endsequence
    sequence lock_close_s;
        st.state == CSB_LOCK && i_lock_seq_end && i_ce;
    endsequence

    lock_assert_a: assert property (@(posedge i_clk_sys) disable iff (!rst_int_n) // RULE10
        lock_open_s |=> !o_bus_lock_n && o_bus_lock_oe)
        else $error("bus lock not asserted at locked sequence start");
    lock_release_a: assert property (@(posedge i_clk_sys) disable iff (!rst_int_n) // RULE10
        lock_close_s |=> o_bus_lock_n)
        else $error("bus lock not released at locked sequence end");
    lock_hold_a: assert property (@(posedge i_clk_sys) disable iff (!rst_int_n) // RULE12
        (!o_bus_lock_n && !(i_lock_seq_end && i_ce)) |=> !o_bus_lock_n && o_bus_own_hold)
        else $error("bus ownership dropped during locked operation");
    exc_raise_a: assert property (@(posedge i_clk_sys) disable iff (!rst_int_n) // RULE2
        (i_ce && i_fp.fp_op_valid && !i_fp.fp_op_control && st.err_pending && !ignore_active)
        |=> o_fp_exception)
        else $error("pending fp error did not raise exception");
    exc_ignore_a: assert property (@(posedge i_clk_sys) disable iff (!rst_int_n) // RULE1
        (i_ce && ignore_active && st.err_pending) |=> !o_fp_exception && o_fp_error_pending)
        else $error("exception raised while error ignored");
    native_mode_a: assert property (@(posedge i_clk_sys) disable iff (!rst_int_n) // RULE3
        (i_ce && i_fp.native_fp_error_bit && i_fp.fp_op_valid && !i_fp.fp_op_control && st.err_pending)
        |=> o_fp_exception)
        else $error("ignore pin acted in native error mode");
    exc_control_a: assert property (@(posedge i_clk_sys) disable iff (!rst_int_n) // RULE2
        (i_ce && !(i_fp.fp_op_valid && !i_fp.fp_op_control)) |=> !o_fp_exception)
        else $error("exception raised without a noncontrol fp op");
    init_restart_a: assert property (@(posedge i_clk_sys) disable iff (!rst_int_n) // RULE6
        $fell(o_int_reg_reset) |-> o_fetch_restart && o_fetch_vector == RESET_VECTOR)
        else $error("soft init did not restart at reset vector");
    snoop_serve_a: assert property (@(posedge i_clk_sys) disable iff (!rst_int_n) // RULE7
        (i_ce && i_snoop_req) |=> o_snoop_ack)
        else $error("snoop not serviced");
    irq_fallback_a: assert property (@(posedge i_clk_sys) disable iff (!rst_int_n) // RULE8
        (i_ce && !o_lapic_enabled) |=> o_maskable_irq == $past(pins.local_irq_pin_zero)
        && o_nmi == $past(pins.local_irq_pin_one))
        else $error("local irq pins not mapped to legacy interrupts");
    lapic_default_a: assert property (@(posedge i_clk_sys) // RULE9
        $rose(rst_int_n) |-> o_lapic_enabled)
        else $error("local controller not enabled after reset");
endmodule

// ==== verification/csb_bus_agent.sv ====
// priority bus agent model that waits for the lock wire to clear before taking the bus
`timescale 1ns/1ns
module csb_bus_agent (
    // clock and reset
    input  wire logic i_clk_sys,
    input  wire logic i_rst_n,
    // lock wire and request
    input  wire logic i_bus_lock_n,
    input  wire logic i_want,
    output logic      o_granted
);
    // ownership is only taken on an edge that sees the lock wire high
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_granted <= 1'b0;
        end else begin
            o_granted <= i_want & i_bus_lock_n;
        end
    end
endmodule

// ==== verification/csb_top_tb.sv ====
// self-checking testbench for the processor sideband control block
`timescale 1ns/1ns
`include "csb_defs.svh"
module csb_top_tb;
    import csb_pkg::*;
    localparam logic [`CSB_VEC_W-1:0] TB_VEC = 32'h0000_FFF0;
    logic                 clk, rst_n, ce, ign_n, init_n, dis, en, l_start, l_end, snoop, want;
    logic [1:0]           irq;
    csb_fp_req_t          fp;
    logic                 exc, pend, ireset, restart, sack, lap_en, mirq, nmi, lock_n, lock_oe, own, granted;
    logic [1:0]           lint;
    logic [`CSB_VEC_W-1:0] vec;
    wire                  lock_wire;
    int                   fails, n_checks;

    // open-drain lock wire with a pull-up
    assign lock_wire = lock_oe ? lock_n : 1'b1;

    csb_top #(
        .RESET_VECTOR(TB_VEC)
    ) u_csb_top (.i_clk_sys(clk), .i_rst_n(rst_n), .i_ce(ce), .i_ignore_fp_error_n(ign_n),
        .i_init_n(init_n), .i_local_irq_pins(irq), .i_fp(fp), .i_lapic_disable(dis), .i_lapic_enable(en),
        .i_lock_seq_start(l_start), .i_lock_seq_end(l_end), .i_snoop_req(snoop), .o_fp_exception(exc),
        .o_fp_error_pending(pend), .o_int_reg_reset(ireset), .o_fetch_restart(restart), .o_fetch_vector(vec),
        .o_snoop_ack(sack), .o_lapic_enabled(lap_en), .o_maskable_irq(mirq), .o_nmi(nmi), .o_lapic_lint(lint),
        .o_bus_lock_n(lock_n), .o_bus_lock_oe(lock_oe), .o_bus_own_hold(own));
    csb_bus_agent u_csb_bus_agent (.i_clk_sys(clk), .i_rst_n(rst_n), .i_bus_lock_n(lock_wire), .i_want(want),
        .o_granted(granted));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic close_out;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ignore pin is settled well before the op, as the system side must do
    task automatic fp_case(input logic ign, input logic nat, input logic exp);
        ign_n = ign;
        fp.native_fp_error_bit = nat;
        cyc(4);
        fp.fp_error_set = 1'b1;
        cyc(1);
        fp.fp_error_set = 1'b0;
        fp.fp_op_valid = 1'b1;
        fp.fp_op_control = 1'b1;
        cyc(1);
        chk("fp_control_op", exc, 1'b0);
        chk("fp_control_pend", pend, 1'b1);
        fp.fp_op_control = 1'b0;
        cyc(1);
        fp.fp_op_valid = 1'b0;
        chk("fp_exception", exc, exp);
        chk("fp_pending", pend, !exp);
    endtask

    task automatic init_case;
        int k;
        fp.fp_error_set = 1'b1;
        cyc(1);
        fp.fp_error_set = 1'b0;
        init_n = 1'b0;
        snoop = 1'b1;
        cyc(2);
        chk("int_reset_early", ireset, 1'b0);
        cyc(2);
        chk("int_reset", ireset, 1'b1);
        chk("snoop_ack", sack, 1'b1);
        init_n = 1'b1;
        snoop = 1'b0;
        k = 0;
        while (restart !== 1'b1 && k < 8) begin
            cyc(1);
            k++;
        end
        chk("fetch_restart", restart, 1'b1);
        chk("fetch_vector", vec, TB_VEC);
        cyc(1);
        chk("int_reset_off", ireset, 1'b0);
        chk("fp_kept", pend, 1'b1);
    endtask

    task automatic lapic_case;
        irq = 2'b10;
        cyc(4);
        chk("lint_default", {lap_en, lint, mirq, nmi}, 5'b11000);
        dis = 1'b1;
        cyc(1);
        dis = 1'b0;
        cyc(1);
        chk("nmi_mode", {lap_en, lint, mirq, nmi}, 5'b00001);
        irq = 2'b01;
        cyc(4);
        chk("maskable_irq_mode", {lint, mirq, nmi}, 4'b0010);
        en = 1'b1;
        cyc(1);
        en = 1'b0;
        cyc(1);
        chk("lint_again", {lap_en, lint, mirq, nmi}, 5'b10100);
    endtask

    task automatic lock_case;
        l_start = 1'b1;
        cyc(1);
        want = 1'b1;
        chk("lock_on", {lock_n, lock_oe, own}, 3'b011);
        // start held one more cycle lands inside the sequence and must not disturb the lock
        cyc(1);
        l_start = 1'b0;
        repeat (4) begin
            cyc(1);
            chk("lock_held", {lock_wire, own, granted}, 3'b010);
        end
        l_end = 1'b1;
        cyc(1);
        l_end = 1'b0;
        chk("lock_off", {lock_n, lock_oe, own}, 3'b100);
        cyc(1);
        chk("agent_grant", granted, 1'b1);
        want = 1'b0;
    endtask

    // clock enable low must freeze snoop answer and lock sequencing
    task automatic ce_case;
        ce = 1'b0;
        snoop = 1'b1;
        l_start = 1'b1;
        cyc(2);
        chk("ce_frozen", {sack, lock_n, own}, 3'b010);
        ce = 1'b1;
        cyc(1);
        l_start = 1'b0;
        snoop = 1'b0;
        chk("ce_resumed", {sack, lock_n, own}, 3'b101);
        l_end = 1'b1;
        cyc(1);
        l_end = 1'b0;
        chk("ce_lock_off", lock_n, 1'b1);
    endtask

    initial begin
        fails = 0;
        n_checks = 0;
        rst_n = 1'b0;
        ce = 1'b1;
        ign_n = 1'b1;
        init_n = 1'b1;
        irq = 2'b00;
        fp = '0;
        {dis, en, l_start, l_end, snoop, want} = 6'h00;
        cyc(3);
        chk("reset_outs", {lap_en, lock_n, lock_oe, exc}, 4'hC);
        chk("reset_vector", vec, TB_VEC);
        cyc(2);
        rst_n = 1'b1;
        cyc(6);
        fp_case(1'b1, 1'b0, 1'b1);
        fp_case(1'b0, 1'b0, 1'b0);
        fp_case(1'b0, 1'b1, 1'b1);
        ign_n = 1'b1;
        fp.native_fp_error_bit = 1'b0;
        init_case();
        lapic_case();
        lock_case();
        ce_case();
        close_out();
    end

    initial begin
        #100000;
        fails++;
        close_out();
    end
endmodule
